// ===== design/epiu_pin_sync.sv
`default_nettype none
`include "epiu_params.svh"

module epiu_pin_sync (
    input wire logic ref_clk,
    input wire logic reset,
    input wire epiu_pkg::epiu_pins_t pins,
    epiu_pin_if.src evt
);
    import epiu_pkg::*;

    epiu_sync_s st;
    epiu_sync_s next_st;
    logic ready;

    // ------------------------------------------------------------
    // Two-stage sampler, then edge compare on settled samples
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.first = pins;
        next_st.second = st.first;
        next_st.prev = st.second;
        next_st.primed = {st.primed[`EPIU_SYNC_PRIME-2:0], 1'b1};
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // No edges until both compare stages hold real samples
    assign ready = st.primed[`EPIU_SYNC_PRIME-1];
    assign evt.level = st.second;
    assign evt.ext_rise = ready & st.second[`EPIU_EXT_IDX] & ~st.prev[`EPIU_EXT_IDX];
    assign evt.ext_fall = ready & ~st.second[`EPIU_EXT_IDX] & st.prev[`EPIU_EXT_IDX];
    assign evt.change = ready ? (st.second[`EPIU_NUM_CHANGE-1:0] ^ st.prev[`EPIU_NUM_CHANGE-1:0]) : '0;

endmodule

`default_nettype wire

// ===== design/epiu_top.sv
// Functional notes
// - Sense field picks low, any, fall, rise
// - External request needs global and mask enables
// - Pin sampled first; pulses over one clock caught
// - Pins trigger even when driven as outputs
// - Triggering edge sets external pending flag
// - Pending and enabled external flag vectors core
// - Flags clear on entry or written one
// - Low-level mode reads external flag as zero
// - Group enable lets masked pins interrupt
// - Enabled pin change sets flag and vectors
// - Mask bits 3:0 enable each change pin
// - Pin-change wake works without clock
// - Low level wakes asynchronously; edges need clock
// - External vector 0x001, pin change 0x002
`default_nettype none
`include "epiu_params.svh"

module epiu_top (
    input wire logic ref_clk,
    input wire logic reset,
    input wire epiu_pkg::epiu_addr_t reg_addr,
    input wire epiu_pkg::epiu_data_t reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output epiu_pkg::epiu_data_t reg_rdata,
    input wire logic ext_pin_irq,
    input wire epiu_pkg::epiu_change_t change_pin,
    input wire logic core_status_gie,
    input wire logic irq_ack,
    output logic irq_request,
    output epiu_pkg::epiu_vec_t irq_vector,
    output logic ext_wake,
    output logic pin_change_wake
);
    import epiu_pkg::*;

    epiu_regs_s st;
    epiu_regs_s next_st;
    epiu_pin_if pin_evt ();

    logic ext_trigger;
    logic pc_trigger;
    logic ext_req;
    logic pc_req;
    logic ack_ext;
    logic ack_pc;
    logic clr_ext;
    logic clr_pc;
    logic level_mode;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic reg_hit(input epiu_addr_t addr, input epiu_addr_t ofs, input logic stb);
        reg_hit = stb && (addr == ofs);
    endfunction

    function automatic logic flag_next(input logic cur, input logic set, input logic clr);
        // A set in the same cycle as a clear wins
        flag_next = set | (cur & ~clr);
    endfunction

    // ------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------
    // Pad levels are read regardless of pin direction
    epiu_pin_sync u_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .pins({ext_pin_irq, change_pin}),
        .evt(pin_evt.src)
    );

    // ------------------------------------------------------------
    // Trigger detection
    // ------------------------------------------------------------
    assign level_mode = (st.sense == EPIU_SENSE_LOW);

    always_comb begin
        case (st.sense)
            EPIU_SENSE_LOW: ext_trigger = 1'b0;
            EPIU_SENSE_ANY: ext_trigger = pin_evt.ext_rise | pin_evt.ext_fall;
            EPIU_SENSE_FALL: ext_trigger = pin_evt.ext_fall;
            EPIU_SENSE_RISE: ext_trigger = pin_evt.ext_rise;
            default: ext_trigger = 1'b0;
        endcase
    end

    assign pc_trigger = |(pin_evt.change & st.pc_mask);

    // ------------------------------------------------------------
    // Requests toward the core
    // ------------------------------------------------------------
    always_comb begin
        if (level_mode) begin
            ext_req = ~pin_evt.level[`EPIU_EXT_IDX] & st.ext_mask & core_status_gie;
        end else begin
            ext_req = st.ext_pending & st.ext_mask & core_status_gie;
        end
    end

    assign pc_req = st.pc_pending & st.pc_group_en & core_status_gie;

    epiu_vector_arb u_arb (
        .ref_clk(ref_clk),
        .reset(reset),
        .ext_req(ext_req),
        .pc_req(pc_req),
        .irq_ack(irq_ack),
        .irq_request(irq_request),
        .irq_vector(irq_vector)
    );

    // Acknowledge clears the flag of the vector being presented
    assign ack_ext = irq_ack && irq_request && (irq_vector == `EPIU_VEC_EXT);
    assign ack_pc = irq_ack && irq_request && (irq_vector == `EPIU_VEC_PIN_CHANGE);

    assign clr_ext = ack_ext |
        (reg_hit(reg_addr, `EPIU_OFS_EXT_IRQ_FLAG, reg_write) & reg_wdata[`EPIU_BIT_EXT_PIN_PENDING]);
    assign clr_pc = ack_pc |
        (reg_hit(reg_addr, `EPIU_OFS_PIN_CHANGE_FLAG, reg_write) & reg_wdata[`EPIU_BIT_PIN_CHANGE_PENDING]);

    // ------------------------------------------------------------
    // Asynchronous wake paths, usable with the clock stopped
    // ------------------------------------------------------------
    // Low level wakes without a clock; edge modes need the clock
    assign ext_wake = level_mode & st.ext_mask & ~ext_pin_irq;
    // Raw pins compared to the last settled sample
    assign pin_change_wake = st.pc_group_en &
        (|((change_pin ^ pin_evt.level[`EPIU_NUM_CHANGE-1:0]) & st.pc_mask));

    // ------------------------------------------------------------
    // Register file and flags
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;

        if (reg_hit(reg_addr, `EPIU_OFS_PIN_CHANGE_MASK, reg_write)) begin
            next_st.pc_mask = reg_wdata[`EPIU_MASK_MSB:`EPIU_MASK_LSB];
        end
        if (reg_hit(reg_addr, `EPIU_OFS_PIN_CHANGE_CONTROL, reg_write)) begin
            next_st.pc_group_en = reg_wdata[`EPIU_BIT_GROUP_ENABLE];
        end
        if (reg_hit(reg_addr, `EPIU_OFS_EXT_IRQ_MASK, reg_write)) begin
            next_st.ext_mask = reg_wdata[`EPIU_BIT_EXT_PIN_IRQ];
        end
        if (reg_hit(reg_addr, `EPIU_OFS_EXT_IRQ_SENSE_CONTROL, reg_write)) begin
            next_st.sense = epiu_sense_e'(reg_wdata[`EPIU_SENSE_MSB:`EPIU_SENSE_LSB]);
        end

        if (level_mode) begin
            next_st.ext_pending = 1'b0;
        end else begin
            next_st.ext_pending = flag_next(st.ext_pending, ext_trigger, clr_ext);
        end
        next_st.pc_pending = flag_next(st.pc_pending, pc_trigger, clr_pc);

        next_st.rdata = '0;
        if (reg_read) begin
            case (reg_addr)
                `EPIU_OFS_PIN_CHANGE_MASK: next_st.rdata = {4'h0, st.pc_mask};
                `EPIU_OFS_PIN_CHANGE_FLAG: next_st.rdata = {7'h00, st.pc_pending};
                `EPIU_OFS_PIN_CHANGE_CONTROL: next_st.rdata = {7'h00, st.pc_group_en};
                `EPIU_OFS_EXT_IRQ_MASK: next_st.rdata = {7'h00, st.ext_mask};
                `EPIU_OFS_EXT_IRQ_FLAG: next_st.rdata = {7'h00, st.ext_pending & ~level_mode};
                `EPIU_OFS_EXT_IRQ_SENSE_CONTROL: next_st.rdata = {6'h00, st.sense};
                default: next_st.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st.pc_mask <= `EPIU_RST_PIN_CHANGE_MASK;
            st.pc_group_en <= `EPIU_RST_PIN_CHANGE_CONTROL;
            st.ext_mask <= `EPIU_RST_EXT_IRQ_MASK;
            st.sense <= EPIU_SENSE_LOW;
            st.ext_pending <= 1'b0;
            st.pc_pending <= 1'b0;
            st.rdata <= `EPIU_RST_RDATA;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;

endmodule

`default_nettype wire

// ===== design/epiu_vector_arb.sv
`default_nettype none
`include "epiu_params.svh"

module epiu_vector_arb (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic ext_req,
    input wire logic pc_req,
    input wire logic irq_ack,
    output logic irq_request,
    output epiu_pkg::epiu_vec_t irq_vector
);
    import epiu_pkg::*;

    epiu_arb_s st;
    epiu_arb_s next_st;

    // ------------------------------------------------------------
    // Fixed priority: lower vector address wins
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        if (irq_ack) begin
            // Skip one cycle so a flag just cleared is not presented again
            next_st.request = 1'b0;
            next_st.vector = `EPIU_VEC_NONE;
        end else if (ext_req) begin
            next_st.request = 1'b1;
            next_st.vector = `EPIU_VEC_EXT;
        end else if (pc_req) begin
            next_st.request = 1'b1;
            next_st.vector = `EPIU_VEC_PIN_CHANGE;
        end else begin
            next_st.request = 1'b0;
            next_st.vector = `EPIU_VEC_NONE;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign irq_request = st.request;
    assign irq_vector = st.vector;

endmodule

`default_nettype wire

// ===== dv/epiu_core_model.sv
`default_nettype none
module epiu_core_model (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic ack_en,
    input wire logic irq_request,
    input wire epiu_pkg::epiu_vec_t irq_vector,
    output logic irq_ack,
    output epiu_pkg::epiu_vec_t taken_vec,
    output logic [7:0] taken_cnt
);
    timeunit 1ns;
    timeprecision 1ns;
    import epiu_pkg::*;
    // Core enters one routine per presented request; ack_en low models a slow core
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            irq_ack <= 1'b0;
            taken_vec <= 4'h0;
            taken_cnt <= 8'h00;
        end else if (irq_ack) begin
            irq_ack <= 1'b0;
            taken_vec <= irq_vector;
            taken_cnt <= taken_cnt + 8'h01;
        end else begin
            irq_ack <= irq_request && ack_en;
        end
    end
endmodule
`default_nettype wire

// ===== dv/epiu_top_sva.sv
`default_nettype none
`include "epiu_params.svh"
module epiu_top_sva (
    input wire logic ref_clk,
    input wire logic reset,
    input wire epiu_pkg::epiu_addr_t reg_addr,
    input wire epiu_pkg::epiu_data_t reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire epiu_pkg::epiu_data_t reg_rdata,
    input wire logic ext_pin_irq,
    input wire epiu_pkg::epiu_change_t change_pin,
    input wire logic core_status_gie,
    input wire logic irq_ack,
    input wire logic irq_request,
    input wire epiu_pkg::epiu_vec_t irq_vector,
    input wire logic ext_wake,
    input wire logic pin_change_wake
);
    timeunit 1ns;
    timeprecision 1ns;
    import epiu_pkg::*;
    logic [1:0] sense;
    logic emask;
    epiu_change_t pmask;
    logic lvl_on;
    assign lvl_on = sense == 2'h0 && emask && core_status_gie && !ext_pin_irq;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sense <= 2'h0;
            emask <= 1'b0;
            pmask <= 4'h0;
        end else if (reg_write) begin
            if (reg_addr == `EPIU_OFS_EXT_IRQ_SENSE_CONTROL) sense <= reg_wdata[1:0];
            if (reg_addr == `EPIU_OFS_EXT_IRQ_MASK) emask <= reg_wdata[0];
            if (reg_addr == `EPIU_OFS_PIN_CHANGE_MASK) pmask <= reg_wdata[3:0];
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    a_level_flag_zero: assert property (reg_read && reg_addr == `EPIU_OFS_EXT_IRQ_FLAG && sense == 2'h0
        |=> reg_rdata == 8'h00) else $error("flag set in level mode");
    a_emask_readback: assert property (reg_read && reg_addr == `EPIU_OFS_EXT_IRQ_MASK
        |=> reg_rdata == {7'h00, emask}) else $error("ext mask readback");
    a_pmask_readback: assert property (reg_read && reg_addr == `EPIU_OFS_PIN_CHANGE_MASK
        |=> reg_rdata == {4'h0, pmask}) else $error("pin mask readback");
    a_gie_gates_req: assert property ((!core_status_gie) [*2] |-> !irq_request)
        else $error("request without global enable");
    a_ack_drops_req: assert property (irq_ack && irq_request |=> !irq_request)
        else $error("request held after ack");
    a_vector_valid: assert property (irq_request |-> irq_vector inside {4'h1, 4'h2})
        else $error("bad vector");
    a_level_request: assert property ((lvl_on && !irq_ack) [*6] |-> irq_request)
        else $error("low level not requested");
    a_ext_wake_level: assert property (ext_wake == (sense == 2'h0 && emask && !ext_pin_irq))
        else $error("ext wake wrong");
    a_pc_wake_quiet: assert property ($stable(change_pin) [*3] |-> !pin_change_wake)
        else $error("wake without change");
    c_ext_taken: cover property (irq_ack && irq_vector == 4'h1);
    c_pc_taken: cover property (irq_ack && irq_vector == 4'h2);
    c_level_req: cover property (lvl_on && irq_request);
endmodule
bind epiu_top epiu_top_sva u_sva (.ref_clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .ext_pin_irq, .change_pin, .core_status_gie, .irq_ack, .irq_request, .irq_vector,
    .ext_wake, .pin_change_wake);
`default_nettype wire

// ===== dv/tb_top.sv
`default_nettype none
`include "epiu_params.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import epiu_pkg::*;
    localparam epiu_addr_t ofs_sns = `EPIU_OFS_EXT_IRQ_SENSE_CONTROL;
    localparam epiu_addr_t ofs_emsk = `EPIU_OFS_EXT_IRQ_MASK;
    localparam epiu_addr_t ofs_eflg = `EPIU_OFS_EXT_IRQ_FLAG;
    localparam epiu_addr_t ofs_pmsk = `EPIU_OFS_PIN_CHANGE_MASK;
    localparam epiu_addr_t ofs_pflg = `EPIU_OFS_PIN_CHANGE_FLAG;
    localparam epiu_addr_t ofs_pctl = `EPIU_OFS_PIN_CHANGE_CONTROL;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    epiu_addr_t reg_addr = 8'h00;
    epiu_data_t reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic ext_pin_irq = 1'b0;
    epiu_change_t change_pin = 4'h0;
    logic core_status_gie = 1'b0;
    logic ack_en = 1'b1;
    logic irq_ack, irq_request, ext_wake, pin_change_wake;
    epiu_data_t reg_rdata;
    epiu_vec_t irq_vector, taken_vec;
    logic [7:0] taken_cnt;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #50 ref_clk = ~ref_clk;
    epiu_top u_dut (.ref_clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .ext_pin_irq, .change_pin, .core_status_gie, .irq_ack, .irq_request, .irq_vector,
        .ext_wake, .pin_change_wake);
    epiu_core_model u_core (.ref_clk, .reset, .ack_en, .irq_request, .irq_vector, .irq_ack,
        .taken_vec, .taken_cnt);
    // ----
    // Bus and compare helpers
    // ----
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr(input epiu_addr_t a, input epiu_data_t d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge ref_clk);
        reg_write <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input epiu_addr_t a, input epiu_data_t exp);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1;
        check(reg_rdata, exp);
        @(posedge ref_clk);
    endtask
    task automatic wait_taken(input logic [7:0] n);
        for (int i = 0; i < 40 && taken_cnt != n; i++) @(posedge ref_clk);
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_regs;
        for (int a = 16; a < 24; a++) rd(8'(a), 8'h00);
        wr(ofs_pmsk, 8'hff);
        rd(ofs_pmsk, 8'h0f);
        wr(ofs_pctl, 8'hff);
        rd(ofs_pctl, 8'h01);
        wr(ofs_sns, 8'hff);
        rd(ofs_sns, 8'h03);
        wr(ofs_emsk, 8'hff);
        rd(ofs_emsk, 8'h01);
        wr(8'h16, 8'hff);
        rd(8'h16, 8'h00);
        wr(ofs_pmsk, 8'h00);
        wr(ofs_pctl, 8'h00);
        wr(ofs_emsk, 8'h00);
    endtask
    task automatic t_edge_modes;
        for (int m = 1; m < 4; m++) begin
            wr(ofs_sns, 8'(m));
            ext_pin_irq <= 1'b1;
            cyc(5);
            rd(ofs_eflg, {7'h00, m != 2});
            wr(ofs_eflg, 8'h01);
            rd(ofs_eflg, 8'h00);
            ext_pin_irq <= 1'b0;
            cyc(5);
            rd(ofs_eflg, {7'h00, m != 3});
            wr(ofs_eflg, 8'h01);
        end
    endtask
    task automatic t_level;
        logic [7:0] c0;
        c0 = taken_cnt;
        wr(ofs_sns, 8'h00);
        wr(ofs_emsk, 8'h01);
        check({7'h00, ext_wake}, 8'h01);
        cyc(8);
        check(taken_cnt, c0);
        ack_en <= 1'b0;
        core_status_gie <= 1'b1;
        cyc(8);
        check({7'h00, irq_request}, 8'h01);
        check({4'h0, irq_vector}, 8'h01);
        rd(ofs_eflg, 8'h00);
        ack_en <= 1'b1;
        wait_taken(c0 + 8'h01);
        check(taken_cnt, c0 + 8'h01);
        check({4'h0, taken_vec}, 8'h01);
        ext_pin_irq <= 1'b1;
        cyc(6);
        check({7'h00, ext_wake}, 8'h00);
        c0 = taken_cnt;
        cyc(6);
        check(taken_cnt, c0);
        core_status_gie <= 1'b0;
    endtask
    task automatic t_priority;
        logic [7:0] c0;
        wr(ofs_sns, 8'h03);
        wr(ofs_pmsk, 8'h01);
        wr(ofs_pctl, 8'h01);
        ext_pin_irq <= 1'b0;
        change_pin <= 4'h2;
        cyc(1);
        check({7'h00, pin_change_wake}, 8'h00);
        cyc(4);
        rd(ofs_pflg, 8'h00);
        rd(ofs_eflg, 8'h00);
        ext_pin_irq <= 1'b1;
        change_pin <= 4'h3;
        cyc(1);
        check({7'h00, pin_change_wake}, 8'h01);
        cyc(1);
        change_pin <= 4'h2;
        cyc(5);
        wr(ofs_pflg, 8'h00);
        rd(ofs_pflg, 8'h01);
        check({7'h00, irq_request}, 8'h00);
        c0 = taken_cnt;
        core_status_gie <= 1'b1;
        wait_taken(c0 + 8'h01);
        check(taken_cnt, c0 + 8'h01);
        check({4'h0, taken_vec}, 8'h01);
        wait_taken(c0 + 8'h02);
        check(taken_cnt, c0 + 8'h02);
        check({4'h0, taken_vec}, 8'h02);
        rd(ofs_eflg, 8'h00);
        rd(ofs_pflg, 8'h00);
        core_status_gie <= 1'b0;
    endtask
    task automatic conclude;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            conclude();
        end
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        cyc(4);
        t_regs();
        t_edge_modes();
        t_level();
        t_priority();
        conclude();
    end
endmodule
`default_nettype wire

// ===== include/epiu_params.svh
`ifndef EPIU_PARAMS_SVH
`define EPIU_PARAMS_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define EPIU_ADDR_W 8
`define EPIU_DATA_W 8
`define EPIU_OFS_PIN_CHANGE_MASK 8'h10
`define EPIU_OFS_PIN_CHANGE_FLAG 8'h11
`define EPIU_OFS_PIN_CHANGE_CONTROL 8'h12
`define EPIU_OFS_EXT_IRQ_MASK 8'h13
`define EPIU_OFS_EXT_IRQ_FLAG 8'h14
`define EPIU_OFS_EXT_IRQ_SENSE_CONTROL 8'h15

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define EPIU_RST_PIN_CHANGE_MASK 4'h0
`define EPIU_RST_PIN_CHANGE_CONTROL 1'b0
`define EPIU_RST_EXT_IRQ_MASK 1'b0
`define EPIU_RST_SENSE 2'h0
`define EPIU_RST_RDATA 8'h00

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define EPIU_BIT_EXT_PIN_IRQ 0
`define EPIU_BIT_EXT_PIN_PENDING 0
`define EPIU_BIT_GROUP_ENABLE 0
`define EPIU_BIT_PIN_CHANGE_PENDING 0
`define EPIU_SENSE_MSB 1
`define EPIU_SENSE_LSB 0
`define EPIU_MASK_MSB 3
`define EPIU_MASK_LSB 0

// ------------------------------------------------------------
// Pins and vectors
// ------------------------------------------------------------
`define EPIU_NUM_CHANGE 4
`define EPIU_NUM_PINS 5
`define EPIU_EXT_IDX 4
`define EPIU_VEC_W 4
`define EPIU_VEC_NONE 4'h0
`define EPIU_VEC_EXT 4'h1
`define EPIU_VEC_PIN_CHANGE 4'h2
`define EPIU_SYNC_PRIME 3

`endif

// ===== include/epiu_pin_if.sv
`default_nettype none

interface epiu_pin_if;
    import epiu_pkg::*;

    epiu_pins_t level;
    logic ext_rise;
    logic ext_fall;
    epiu_change_t change;

    modport src (output level, output ext_rise, output ext_fall, output change);
    modport dst (input level, input ext_rise, input ext_fall, input change);
endinterface

`default_nettype wire

// ===== include/epiu_pkg.sv
`default_nettype none
`include "epiu_params.svh"

package epiu_pkg;

    typedef logic [`EPIU_ADDR_W-1:0] epiu_addr_t;
    typedef logic [`EPIU_DATA_W-1:0] epiu_data_t;
    typedef logic [`EPIU_VEC_W-1:0] epiu_vec_t;
    typedef logic [`EPIU_NUM_PINS-1:0] epiu_pins_t;
    typedef logic [`EPIU_NUM_CHANGE-1:0] epiu_change_t;

    // Sense select encodings as held in the register field
    typedef enum logic [1:0] {
        EPIU_SENSE_LOW = 2'h0,
        EPIU_SENSE_ANY = 2'h1,
        EPIU_SENSE_FALL = 2'h2,
        EPIU_SENSE_RISE = 2'h3
    } epiu_sense_e;

    typedef struct packed {
        epiu_pins_t first;
        epiu_pins_t second;
        epiu_pins_t prev;
        logic [`EPIU_SYNC_PRIME-1:0] primed;
    } epiu_sync_s;

    typedef struct packed {
        logic request;
        epiu_vec_t vector;
    } epiu_arb_s;

    typedef struct packed {
        epiu_change_t pc_mask;
        logic pc_group_en;
        logic ext_mask;
        epiu_sense_e sense;
        logic ext_pending;
        logic pc_pending;
        epiu_data_t rdata;
    } epiu_regs_s;

endpackage

`default_nettype wire
